// file: hdl/msnss_top.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Stop notification and synchronous start command block
module msnss_top
    import msnss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] moving,
    output logic rate_load,
    output msnss_rate_t rate,
    output logic [15:0] start_mask,
    output logic [15:0] standby_mask,
    output logic srq,
    output logic [7:0] poll_status,
    output logic msg_valid,
    output msnss_msg_t msg,
    input wire logic msg_ready
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic remote_ff;
    logic [23:0] speed_ff;
    logic standby_ff;
    logic [15:0] standby_mask_ff;
    logic [15:0] queued_ff;
    logic [15:0] start_mask_ff;
    logic rate_load_ff;
    msnss_rate_t rate_ff;
    logic err_ff;
    logic srq_ff;
    logic [15:0] signalled_ff;
    logic [15:0] query_ff;
    logic [15:0] moving_q_ff;
    logic [2:0] port_ff [MSNSS_NSET];
    logic [15:0] pend_ff [MSNSS_NSET];
    logic msg_valid_ff;
    msnss_msg_t msg_ff;
    logic [15:0] flags [MSNSS_NSET];
    logic [15:0] auto_clr [MSNSS_NSET];
    logic [15:0] pick_req;
    logic pick_any;
    logic [3:0] pick_ch;
    logic [1:0] pick_if;
    logic apb_done;
    logic wr_done;
    logic rd_done;
    logic cmd_go;
    msnss_cmd_t cmd;
    logic [15:0] stopped;
    logic [15:0] bus_fire;
    logic sent;
    logic speed_ok;
    logic addr_ok;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    // Writes, commands and read clears act only in that ready cycle
    assign apb_done = psel & penable & pready_ff;
    assign wr_done = apb_done & pwrite;
    assign rd_done = apb_done & ~pwrite;
    assign cmd = msnss_cmd_t'(pwdata);
    assign cmd_go = wr_done & (paddr == MSNSS_CMD_OFS);

    // Address decode shared by read and error answer
    // Unmapped offsets read zero and drop writes; the error flag says so
    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            MSNSS_CTRL_OFS: rd_mux[MSNSS_CTRL_REMOTE_BIT] = remote_ff;
            MSNSS_CMD_OFS: rd_mux = 32'h0000_0000;
            MSNSS_SPEED_OFS: rd_mux[23:0] = speed_ff;
            MSNSS_STATUS_OFS: begin
                rd_mux[MSNSS_ST_STANDBY_BIT] = standby_ff;
                rd_mux[MSNSS_ST_SRQ_BIT] = srq_ff;
                rd_mux[MSNSS_ST_ERR_BIT] = err_ff;
                rd_mux[MSNSS_ST_MSGV_BIT] = msg_valid_ff;
            end
            MSNSS_SIGNALLED_OFS: rd_mux[15:0] = signalled_ff;
            MSNSS_QUERY_OFS: rd_mux[15:0] = query_ff;
            MSNSS_POLL_OFS: rd_mux[7:0] = srq_ff ? MSNSS_POLL_SRQ : 8'h00;
            MSNSS_FLAGS_OFS: rd_mux = {flags[MSNSS_IF_FAST], flags[MSNSS_IF_BUS]};
            MSNSS_PEND_OFS: rd_mux = {flags[MSNSS_IF_SERIAL], flags[MSNSS_IF_NORMAL]};
            default: addr_ok = 1'b0;
        endcase
    end

    // Read data captured in the wait cycle, held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~addr_ok;
            if (psel && penable && !pready_ff && !pwrite) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    // Control and speed value registers
    // Speed is only a staging value; the speed command applies it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_ff <= 1'b0;
            speed_ff <= MSNSS_SPEED_RST;
        end else if (wr_done && paddr == MSNSS_CTRL_OFS) begin
            remote_ff <= pwdata[MSNSS_CTRL_REMOTE_BIT];
        end else if (wr_done && paddr == MSNSS_SPEED_OFS) begin
            speed_ff <= pwdata[23:0];
        end
    end

    // ------------------------------------------------------------
    // Speed change while moving
    // ------------------------------------------------------------
    // Out of range, local mode or idle motor is refused with err
    // A refused command leaves the last accepted rate standing
    assign speed_ok = (speed_ff >= MSNSS_SPEED_MIN) && (speed_ff <= MSNSS_SPEED_MAX)
        && remote_ff && moving[cmd.ch];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_load_ff <= 1'b0;
            rate_ff <= '0;
            err_ff <= 1'b0;
        end else begin
            rate_load_ff <= cmd_go && cmd.op == MSNSS_OP_SPEED && speed_ok;
            if (cmd_go && cmd.op == MSNSS_OP_SPEED) begin
                err_ff <= ~speed_ok;
                if (speed_ok) begin
                    rate_ff <= '{ch: cmd.ch, rate: speed_ff};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Standby and synchronous start
    // ------------------------------------------------------------
    // Queued moves live as one bit per channel; a second move for
    // the same channel while held simply stays queued once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_ff <= 1'b0;
            standby_mask_ff <= 16'h0000;
            queued_ff <= 16'h0000;
            start_mask_ff <= 16'h0000;
        end else begin
            start_mask_ff <= 16'h0000;
            if (cmd_go && cmd.op == MSNSS_OP_HOLD_ON && remote_ff) begin
                standby_ff <= 1'b1;
                standby_mask_ff <= ~moving;
            end else if (cmd_go && cmd.op == MSNSS_OP_HOLD_OFF && remote_ff) begin
                standby_ff <= 1'b0;
                standby_mask_ff <= 16'h0000;
                queued_ff <= 16'h0000;
                start_mask_ff <= queued_ff;
            end else if (cmd_go && cmd.op == MSNSS_OP_MOVE && remote_ff) begin
                if (standby_ff) begin
                    queued_ff[cmd.ch] <= 1'b1;
                end else begin
                    start_mask_ff[cmd.ch] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Stop detection and notify flag sets
    // ------------------------------------------------------------
    // Moving comes from our own clock domain, so one flop finds a stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            moving_q_ff <= 16'h0000;
        end else begin
            moving_q_ff <= moving;
        end
    end

    // A stop is a falling moving bit; only armed channels report
    assign stopped = moving_q_ff & ~moving;
    assign bus_fire = stopped & flags[MSNSS_IF_BUS];
    assign sent = msg_valid_ff & msg_ready;

    // Four independent sets: bus, fast net, normal net, serial
    // The bus set keeps no pending list: its request line rises
    // at once and needs no handshake, so pend_ff[0] stays clear.
    for (genvar s = 0; s < MSNSS_NSET; s++) begin : g_set
        if (s == 0) begin : g_bus
            assign auto_clr[s] = bus_fire;
        end else begin : g_net
            assign auto_clr[s] = (sent && msg_ff.iface == 2'(s))
                ? (16'h0001 << msg_ff.ch) : 16'h0000;
        end

        msnss_flag_set u_flags (
            .pclk(pclk),
            .presetn(presetn),
            .cmd_en(cmd_go && cmd.op == MSNSS_OP_FLAG && cmd.iface == 2'(s)),
            .cmd_ch(cmd.ch),
            .cmd_mode(cmd.mode),
            .cmd_all(cmd.all),
            .auto_clr(auto_clr[s]),
            .flags(flags[s])
        );

        // Reply port tracks the last flag-set command per interface
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                port_ff[s] <= 3'h0;
            end else if (cmd_go && cmd.op == MSNSS_OP_FLAG && cmd.iface == 2'(s)
                && cmd.mode && !cmd.all) begin
                port_ff[s] <= cmd.port;
            end
        end

        // Pending stop reports; an armed stop is never dropped
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pend_ff[s] <= 16'h0000;
            end else if (s != 0) begin
                pend_ff[s] <= (pend_ff[s] & ~auto_clr[s]) | (stopped & flags[s]);
            end
        end
    end

    // ------------------------------------------------------------
    // Bus service request and signalled bitmap
    // ------------------------------------------------------------
    // A stop in the cycle of the clearing read is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srq_ff <= 1'b0;
            signalled_ff <= 16'h0000;
        end else begin
            if (rd_done && paddr == MSNSS_SIGNALLED_OFS) begin
                signalled_ff <= bus_fire;
                srq_ff <= |bus_fire;
            end else begin
                signalled_ff <= signalled_ff | bus_fire;
                srq_ff <= srq_ff | (|bus_fire);
            end
        end
    end

    // ------------------------------------------------------------
    // Queries
    // ------------------------------------------------------------
    // Answer latched at the query command, read back by the host later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            query_ff <= 16'h0000;
        end else if (cmd_go && cmd.op == MSNSS_OP_HOLD_QUERY) begin
            query_ff <= {15'h0000, standby_ff};
        end else if (cmd_go && cmd.op == MSNSS_OP_FLAG_QUERY) begin
            if (cmd.all) begin
                query_ff <= flags[cmd.iface];
            end else begin
                query_ff <= {15'h0000, flags[cmd.iface][cmd.ch]};
            end
        end
    end

    // ------------------------------------------------------------
    // Stop message sender
    // ------------------------------------------------------------
    // Fixed priority fast, normal, serial; fairness was traded for
    // size since a report burst is at most sixteen per interface.
    // Limitation: a busy fast link holds back normal and serial reports.
    always_comb begin
        pick_if = MSNSS_IF_SERIAL;
        if (|pend_ff[MSNSS_IF_FAST]) begin
            pick_if = MSNSS_IF_FAST;
        end else if (|pend_ff[MSNSS_IF_NORMAL]) begin
            pick_if = MSNSS_IF_NORMAL;
        end
        pick_req = pend_ff[pick_if];
    end

    msnss_pick u_pick (
        .req(pick_req),
        .any(pick_any),
        .idx(pick_ch)
    );

    // Message holds until taken, then the next one is picked
    // The slot idles one cycle after each accept, so a burst costs
    // two cycles per report at best.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_valid_ff <= 1'b0;
            msg_ff <= '0;
        end else if (!msg_valid_ff || sent) begin
            msg_valid_ff <= pick_any && !sent;
            msg_ff <= '{iface: pick_if, port: port_ff[pick_if], ch: pick_ch};
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Straight from flops, no logic between register and pin
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign rate_load = rate_load_ff;
    assign rate = rate_ff;
    assign start_mask = start_mask_ff;
    assign standby_mask = standby_mask_ff;
    assign srq = srq_ff;
    assign msg_valid = msg_valid_ff;
    assign msg = msg_ff;

    // Poll byte kept in its own flop to stay a direct register
    // It also stays up one cycle after a clearing read drops srq.
    logic [7:0] poll_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_ff <= 8'h00;
        end else begin
            poll_ff <= (srq_ff | (|bus_fire)) ? MSNSS_POLL_SRQ : 8'h00;
        end
    end
    assign poll_status = poll_ff;

endmodule : msnss_top

// file: hdl/msnss_pkg.sv
//
// Contract
// - Speed change loads new rate, 5 to 10000000
// - Hold-all-on puts idle motors into standby
// - Standby queues every received move command
// - Hold-all-off starts all queued moves together
// - Standby query answers on or off
// - Armed channel stop raises request or message
// - Serial poll byte reads 0x10 on request
// - Signalled-channel bitmap, bit n is channel n
// - Reading signalled bitmap clears it
// - Bus flag command: mode 0 clears, 1 sets
// - All-channels mode 0 clears every bus flag
// - Bus flag self-clears when request issued
// - Bus flag query: single bit or bitmap
// - Separate flag sets: fast, normal, serial
// - Messages go to last flag-setting port
// - Net flag command: set, clear, clear all
// - Net flag clears once message sent
// - Net flag query: single bit or bitmap
package msnss_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] MSNSS_CTRL_OFS = 8'h00;
    localparam logic [7:0] MSNSS_CMD_OFS = 8'h04;
    localparam logic [7:0] MSNSS_SPEED_OFS = 8'h08;
    localparam logic [7:0] MSNSS_STATUS_OFS = 8'h0c;
    localparam logic [7:0] MSNSS_SIGNALLED_OFS = 8'h10;
    localparam logic [7:0] MSNSS_QUERY_OFS = 8'h14;
    localparam logic [7:0] MSNSS_POLL_OFS = 8'h18;
    localparam logic [7:0] MSNSS_FLAGS_OFS = 8'h1c;
    localparam logic [7:0] MSNSS_PEND_OFS = 8'h20;

    // ------------------------------------------------------------
    // Field positions and constants
    // ------------------------------------------------------------
    localparam int MSNSS_CTRL_REMOTE_BIT = 0;
    localparam int MSNSS_ST_STANDBY_BIT = 0;
    localparam int MSNSS_ST_SRQ_BIT = 1;
    localparam int MSNSS_ST_ERR_BIT = 2;
    localparam int MSNSS_ST_MSGV_BIT = 3;
    localparam logic [7:0] MSNSS_POLL_SRQ = 8'h10;
    localparam logic [23:0] MSNSS_SPEED_MIN = 24'h000005;
    localparam logic [23:0] MSNSS_SPEED_MAX = 24'h989680;
    localparam logic [23:0] MSNSS_SPEED_RST = 24'h000005;
    localparam int MSNSS_NCH = 16;
    localparam int MSNSS_NSET = 4;

    // Interface index; 0 is the instrument bus
    localparam logic [1:0] MSNSS_IF_BUS = 2'h0;
    localparam logic [1:0] MSNSS_IF_FAST = 2'h1;
    localparam logic [1:0] MSNSS_IF_NORMAL = 2'h2;
    localparam logic [1:0] MSNSS_IF_SERIAL = 2'h3;

    typedef enum logic [3:0] {
        MSNSS_OP_NOP = 4'h0,
        MSNSS_OP_SPEED = 4'h1,
        MSNSS_OP_HOLD_ON = 4'h2,
        MSNSS_OP_HOLD_OFF = 4'h3,
        MSNSS_OP_MOVE = 4'h4,
        MSNSS_OP_HOLD_QUERY = 4'h5,
        MSNSS_OP_FLAG = 4'h6,
        MSNSS_OP_FLAG_QUERY = 4'h7
    } msnss_op_t;

    // Command word, written to the command register
    typedef struct packed {
        logic [16:0] rsvd;
        logic [2:0] port;
        logic [1:0] iface;
        logic all;
        logic mode;
        logic [3:0] ch;
        msnss_op_t op;
    } msnss_cmd_t;

    // Stop report handed to the link side
    typedef struct packed {
        logic [1:0] iface;
        logic [2:0] port;
        logic [3:0] ch;
    } msnss_msg_t;

    // Rate load towards the pulse generator
    typedef struct packed {
        logic [3:0] ch;
        logic [23:0] rate;
    } msnss_rate_t;

endpackage : msnss_pkg

// file: hdl/msnss_flag_set.sv
`timescale 1ns/1ps
// One set of sixteen notify flags with its command and auto clear
module msnss_flag_set
    import msnss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_en,
    input wire logic [3:0] cmd_ch,
    input wire logic cmd_mode,
    input wire logic cmd_all,
    input wire logic [15:0] auto_clr,
    output logic [15:0] flags
);

    logic [15:0] flags_ff;
    logic [15:0] nxt_flags;

    // ------------------------------------------------------------
    // Flag update
    // ------------------------------------------------------------
    // A set command wins over an auto clear in the same cycle
    always_comb begin
        nxt_flags = flags_ff & ~auto_clr;
        if (cmd_en && cmd_all && !cmd_mode) begin
            nxt_flags = 16'h0000;
        end else if (cmd_en && !cmd_all) begin
            nxt_flags[cmd_ch] = cmd_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= 16'h0000;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;

endmodule : msnss_flag_set

// file: hdl/msnss_pick.sv
`timescale 1ns/1ps
// Lowest set bit of a sixteen bit request vector
module msnss_pick
    import msnss_pkg::*;
(
    input wire logic [15:0] req,
    output logic any,
    output logic [3:0] idx
);

    // Scan from the top so the lowest channel is left standing
    always_comb begin
        idx = 4'h0;
        for (int i = MSNSS_NCH - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
    end

    assign any = |req;

endmodule : msnss_pick

// file: bench/msnss_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the command block
// ------------------------------------------------------------
module msnss_props
    import msnss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] moving,
    input wire logic rate_load,
    input wire msnss_rate_t rate,
    input wire logic [15:0] start_mask,
    input wire logic srq,
    input wire logic [7:0] poll_status,
    input wire logic msg_valid,
    input wire msnss_msg_t msg,
    input wire logic msg_ready
);
    // One clock domain, so one default for all
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Bus answer: exactly one wait state
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after one wait state");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    // Poll byte rises with the request line on set and lags it by one cycle on clear
    poll_byte_a: assert property (srq && $past(srq) |-> poll_status == MSNSS_POLL_SRQ)
        else $error("poll byte wrong under request");
    // Pulse outputs towards the motor core
    rate_range_a: assert property (
        rate_load |-> rate.rate inside {[MSNSS_SPEED_MIN:MSNSS_SPEED_MAX]})
        else $error("rate loaded out of range");
    rate_pulse_a: assert property (rate_load |=> !rate_load)
        else $error("rate load longer than a cycle");
    start_pulse_a: assert property (|start_mask |=> start_mask == 16'h0000)
        else $error("start mask longer than a cycle");
    // A request needs a falling moving bit two edges back
    srq_cause_a: assert property ($rose(srq) |-> |($past(moving, 2) & ~$past(moving)))
        else $error("request without a stop");
    msg_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg))
        else $error("message changed before accept");
    // Main scenarios reached
    cover property (rate_load);
    cover property ($rose(srq));
    cover property (msg_valid && msg_ready);
endmodule : msnss_props

bind msnss_top msnss_props msnss_props_inst (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .moving, .rate_load, .rate, .start_mask, .srq, .poll_status, .msg_valid,
    .msg, .msg_ready);

// file: bench/msnss_link_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Link host: takes stop reports, odd channels after a stall
// ------------------------------------------------------------
module msnss_link_host
    import msnss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic msg_valid,
    input wire msnss_msg_t msg,
    output logic msg_ready,
    output logic [63:0] seen_ff,
    output logic [11:0] ports_ff
);
    logic [1:0] wait_ff;
    logic rdy_ff;

    assign msg_ready = rdy_ff;

    // Ready drops after each accept, so no report is taken twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_ff <= 1'b0;
            wait_ff <= 2'h0;
        end else if (msg_valid && rdy_ff) begin
            rdy_ff <= 1'b0;
            wait_ff <= 2'h0;
        end else if (msg_valid) begin
            rdy_ff <= !msg.ch[0] || wait_ff == 2'h2;
            wait_ff <= wait_ff + 2'h1;
        end
    end

    // Log by interface and channel, and the port last used
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ff <= 64'h0;
            ports_ff <= 12'h000;
        end else if (msg_valid && rdy_ff) begin
            seen_ff[{msg.iface, msg.ch}] <= 1'b1;
            ports_ff[msg.iface * 3 +: 3] <= msg.port;
        end
    end
endmodule : msnss_link_host

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import msnss_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic rate_load, srq, msg_valid, msg_ready;
    logic [7:0] paddr, poll_status;
    logic [31:0] pwdata, prdata, rd_q;
    logic [15:0] moving, start_mask, standby_mask, seen_start;
    logic [63:0] seen;
    logic [11:0] ports;
    msnss_rate_t rate;
    msnss_msg_t msg;
    int n_fail, n_compared, cyc;

    msnss_top msnss_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .moving, .rate_load, .rate, .start_mask, .standby_mask,
        .srq, .poll_status, .msg_valid, .msg, .msg_ready);
    msnss_link_host msnss_link_host_inst (.pclk, .presetn, .msg_valid, .msg, .msg_ready,
        .seen_ff(seen), .ports_ff(ports));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Start pulses collected; a hang ends the run
    always @(posedge pclk) begin
        seen_start <= seen_start | start_mask;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One bus transfer; ready, read data and error taken at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic cmd(input logic [31:0] c);
        apb(1'b1, MSNSS_CMD_OFS, c);
    endtask : cmd

    function automatic logic [31:0] cw(msnss_op_t op, logic [3:0] ch = 4'h0,
        logic md = 1'b0, logic al = 1'b0, logic [1:0] fi = 2'h0, logic [2:0] pt = 3'h0);
        return {17'h0, pt, fi, al, md, ch, op};
    endfunction : cw

    task automatic t_reset();
        rd(MSNSS_STATUS_OFS);
        chk({rd_q, poll_status, srq}, 41'h0);
        rd(8'h24);
        chk({err_q, rd_q}, {1'b1, 32'h0});
        $display("reset test done");
    endtask : t_reset

    // Both range ends, each side of them
    task automatic t_speed();
        logic [31:0] spd [4] = '{32'h989680, 32'h989681, 32'h4, 32'h5};
        logic [27:0] exp_r;
        exp_r = 28'h0;
        moving <= 16'h000c;
        apb(1'b1, MSNSS_CTRL_OFS, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, MSNSS_SPEED_OFS, spd[i]);
            cmd(cw(MSNSS_OP_SPEED, 4'h2 + {3'h0, i[0]}));
            rd(MSNSS_STATUS_OFS);
            if (i[0] == i[1]) exp_r = {4'h2 + {3'h0, i[0]}, spd[i][23:0]};
            chk({rd_q[MSNSS_ST_ERR_BIT], rate}, {i[0] != i[1], exp_r});
        end
        $display("speed test done");
    endtask : t_speed

    task automatic t_standby();
        cmd(cw(MSNSS_OP_HOLD_ON));
        cmd(cw(MSNSS_OP_HOLD_QUERY));
        rd(MSNSS_QUERY_OFS);
        chk({standby_mask, rd_q}, {16'hfff3, 32'h1});
        cmd(cw(MSNSS_OP_MOVE, 4'h1));
        rd(MSNSS_STATUS_OFS);
        chk({seen_start, rd_q[MSNSS_ST_STANDBY_BIT]}, {16'h0, 1'b1});
        cmd(cw(MSNSS_OP_HOLD_OFF));
        cmd(cw(MSNSS_OP_MOVE, 4'h4));
        cmd(cw(MSNSS_OP_HOLD_QUERY));
        rd(MSNSS_QUERY_OFS);
        chk({standby_mask, seen_start, rd_q}, {16'h0, 16'h0012, 32'h0});
        $display("standby test done");
    endtask : t_standby

    task automatic t_bus();
        cmd(cw(MSNSS_OP_FLAG, 4'h5, 1'b1));
        cmd(cw(MSNSS_OP_FLAG, 4'h9, 1'b1));
        cmd(cw(MSNSS_OP_FLAG_QUERY, 4'h0, 1'b0, 1'b1));
        rd(MSNSS_QUERY_OFS);
        chk(rd_q, 32'h0220);
        cmd(cw(MSNSS_OP_FLAG, 4'h9));
        cmd(cw(MSNSS_OP_FLAG_QUERY, 4'h5));
        rd(MSNSS_QUERY_OFS);
        chk(rd_q, 32'h1);
        cmd(cw(MSNSS_OP_FLAG, 4'h0, 1'b0, 1'b1));
        rd(MSNSS_FLAGS_OFS);
        chk(rd_q, 32'h0);
        cmd(cw(MSNSS_OP_FLAG, 4'h3, 1'b1));
        moving <= 16'h0004;
        repeat (3) @(posedge pclk);
        chk({srq, poll_status}, {1'b1, MSNSS_POLL_SRQ});
        rd(MSNSS_SIGNALLED_OFS);
        chk(rd_q, 32'h0008);
        rd(MSNSS_SIGNALLED_OFS);
        chk(rd_q, 32'h0);
        rd(MSNSS_FLAGS_OFS);
        chk(rd_q, 32'h0);
        $display("bus notify test done");
    endtask : t_bus

    // Three sets at once; fast port is moved before the stop
    task automatic t_net();
        moving <= 16'h004c;
        cmd(cw(MSNSS_OP_FLAG, 4'h3, 1'b1, 1'b0, MSNSS_IF_FAST, 3'h2));
        cmd(cw(MSNSS_OP_FLAG, 4'h3, 1'b1, 1'b0, MSNSS_IF_FAST, 3'h5));
        cmd(cw(MSNSS_OP_FLAG, 4'h1, 1'b1, 1'b0, MSNSS_IF_NORMAL, 3'h1));
        cmd(cw(MSNSS_OP_FLAG, 4'h0, 1'b0, 1'b1, MSNSS_IF_NORMAL));
        cmd(cw(MSNSS_OP_FLAG, 4'h3, 1'b1, 1'b0, MSNSS_IF_NORMAL, 3'h1));
        cmd(cw(MSNSS_OP_FLAG, 4'h6, 1'b1, 1'b0, MSNSS_IF_SERIAL));
        cmd(cw(MSNSS_OP_FLAG_QUERY, 4'h0, 1'b0, 1'b1, MSNSS_IF_SERIAL));
        rd(MSNSS_QUERY_OFS);
        chk(rd_q, 32'h0040);
        cmd(cw(MSNSS_OP_FLAG_QUERY, 4'h1, 1'b0, 1'b0, MSNSS_IF_NORMAL));
        rd(MSNSS_QUERY_OFS);
        chk(rd_q, 32'h0);
        rd(MSNSS_FLAGS_OFS);
        chk(rd_q, 32'h0008_0000);
        moving <= 16'h0004;
        for (int n = 0; n < 200 && seen !== 64'h0040_0008_0008_0000; n++) @(negedge pclk);
        @(posedge pclk);
        chk({ports, seen}, {12'h068, 64'h0040_0008_0008_0000});
        rd(MSNSS_PEND_OFS);
        chk(rd_q, 32'h0);
        $display("net notify test done");
    endtask : t_net

    task automatic close_out();
        $display("compared %0d, wrong %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        moving = 16'h0;
        seen_start = 16'h0;
        {n_fail, n_compared, cyc} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_speed();
        t_standby();
        t_bus();
        t_net();
        close_out();
    end
endmodule : tb_top
